// [rtl/capture_compare_irq_routing.sv]
// Interrupt routing stage: enables and pointers steer unit events onto
// four service request lines; registers reached over APB.
// Assumes event inputs are one-cycle pulses from logic on pclk.
//
// How it works
// R1 - Enabled event pulses its group's chosen line
// R2 - Pointer value n selects service line n
// R3 - Bits 1:0 route channel zero events
// R4 - Bits 3:2 route channel one events
// R5 - Bits 5:4 route channel two events
// R6 - Bits 7:6 route hall-ok and shadow events
// R7 - Bits 9:8 route trap and wrong-hall events
// R8 - Bits 11:10 route first timer events
// R9 - Bits 13:12 route second timer events
// R10 - Pointer bits 15:14 always read zero
// R11 - Cleared enable suppresses, set enable passes
// R12 - Events sharing a line are ORed
`timescale 1ns/1ps
`include "irq_route_consts.svh"
module capture_compare_irq_routing
  import irq_route_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Unit events
  input wire event_set_t events,
  // Service request lines
  output service_lines_t lines
);

  // Pointer register and enable register
  logic [15:0] irq_line_pointer_reg;
  logic [15:0] irq_line_pointer_next;
  logic [15:0] irq_enable_reg;
  logic [15:0] irq_enable_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic [3:0] lines_next;

  // Decode of one two-bit pointer field into a one-hot line set
  function automatic logic [3:0] line_onehot(input logic [1:0] sel,
                                             input logic fire);
    line_onehot = fire ? (4'h1 << sel) : 4'h0; // R2
  endfunction

  // Byte-lane merge for a 16-bit register under write strobes
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st,
                                             input logic [15:0] msk);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    lane_merge = m & msk;
  endfunction

  // Access decode: APB access phase, one-cycle answer
  wire access = psel & penable;
  wire hit_ptr = (paddr == `PTR_REG_OFFSET);
  wire hit_en = (paddr == `EN_REG_OFFSET);
  wire hit_any = hit_ptr | hit_en;
  wire wr_ptr = access & pwrite & hit_ptr & ~pready;
  wire wr_en = access & pwrite & hit_en & ~pready;

  // Register next values; reserved bits forced to zero
  assign irq_line_pointer_next = wr_ptr ?
    lane_merge(irq_line_pointer_reg, pwdata, pstrb, `PTR_RW_MASK) :
    irq_line_pointer_reg; // R10
  assign irq_enable_next = wr_en ?
    lane_merge(irq_enable_reg, pwdata, pstrb, `EN_RW_MASK) :
    irq_enable_reg;

  // Read mux; unmapped addresses read zero and flag an error
  assign prdata_next = hit_ptr ? {16'h0000, irq_line_pointer_reg} :
                       hit_en ? {16'h0000, irq_enable_reg} : 32'h0;
  assign pslverr_next = ~hit_any;

  // Enabled events: a cleared enable bit masks the pulse
  wire [15:0] ev_raw = {events.shadow_xfer_flag, 1'b0,
    events.hall_wrong_flag, events.hall_ok_flag, 1'b0,
    events.trap_flag, events.timer_b_period_flag,
    events.timer_b_compare_flag, events.timer_a_period_flag,
    events.timer_a_one_match_flag, events.chan2_fall_flag,
    events.chan2_rise_flag, events.chan1_fall_flag,
    events.chan1_rise_flag, events.chan0_fall_flag,
    events.chan0_rise_flag};
  wire [15:0] ev_en = ev_raw & irq_enable_reg; // R11

  // Per-group firing
  wire fire_c0 = ev_en[`EV_CHAN0_RISE] | ev_en[`EV_CHAN0_FALL];
  wire fire_c1 = ev_en[`EV_CHAN1_RISE] | ev_en[`EV_CHAN1_FALL];
  wire fire_c2 = ev_en[`EV_CHAN2_RISE] | ev_en[`EV_CHAN2_FALL];
  wire fire_ok = ev_en[`EV_HALL_OK] | ev_en[`EV_SHADOW];
  wire fire_er = ev_en[`EV_TRAP] | ev_en[`EV_HALL_WRONG];
  wire fire_ta = ev_en[`EV_TIMER_A_ONE] | ev_en[`EV_TIMER_A_PER];
  wire fire_tb = ev_en[`EV_TIMER_B_CMP] | ev_en[`EV_TIMER_B_PER];

  // Group routes through their pointer fields
  wire [3:0] route_c0 = line_onehot(
    irq_line_pointer_reg[`CHAN0_SEL_LSB +: 2], fire_c0); // R3
  wire [3:0] route_c1 = line_onehot(
    irq_line_pointer_reg[`CHAN1_SEL_LSB +: 2], fire_c1); // R4
  wire [3:0] route_c2 = line_onehot(
    irq_line_pointer_reg[`CHAN2_SEL_LSB +: 2], fire_c2); // R5
  wire [3:0] route_ok = line_onehot(
    irq_line_pointer_reg[`HALL_OK_SEL_LSB +: 2], fire_ok); // R6
  wire [3:0] route_er = line_onehot(
    irq_line_pointer_reg[`ERROR_SEL_LSB +: 2], fire_er); // R7
  wire [3:0] route_ta = line_onehot(
    irq_line_pointer_reg[`TIMER_A_SEL_LSB +: 2], fire_ta); // R8
  wire [3:0] route_tb = line_onehot(
    irq_line_pointer_reg[`TIMER_B_SEL_LSB +: 2], fire_tb); // R9

  // Shared lines combine by OR so no source is lost
  assign lines_next = route_c0 | route_c1 | route_c2 | route_ok |
                      route_er | route_ta | route_tb; // R12

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line_pointer_reg <= `PTR_RESET;
      irq_enable_reg <= `EN_RESET;
    end else begin
      irq_line_pointer_reg <= irq_line_pointer_next;
      irq_enable_reg <= irq_enable_next;
    end
  end

  // APB answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      prdata <= prdata_next;
      pslverr <= access & ~pready & pslverr_next;
    end
  end

  // Service lines registered: one-cycle pulse, one cycle after event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= '0;
    end else begin
      lines <= lines_next; // R1
    end
  end

endmodule

// [rtl/irq_route_consts.svh]
// Constants for the capture/compare interrupt routing stage.
// Assumes inclusion by bare name; definitions only.
`ifndef IRQ_ROUTE_CONSTS_SVH
`define IRQ_ROUTE_CONSTS_SVH
// Register byte offsets
`define PTR_REG_OFFSET 12'h048
`define EN_REG_OFFSET 12'h044
// Pointer field positions (low bit of each two-bit field)
`define CHAN0_SEL_LSB 0
`define CHAN1_SEL_LSB 2
`define CHAN2_SEL_LSB 4
`define HALL_OK_SEL_LSB 6
`define ERROR_SEL_LSB 8
`define TIMER_A_SEL_LSB 10
`define TIMER_B_SEL_LSB 12
// Writable pointer bits; 15:14 read as zero
`define PTR_RW_MASK 16'h3fff
// Enable register writable bits; 11 reserved
`define EN_RW_MASK 16'hf7ff
// Reset values
`define PTR_RESET 16'h0000
`define EN_RESET 16'h0000
// Event bit positions inside the event vector
`define EV_CHAN0_RISE 0
`define EV_CHAN0_FALL 1
`define EV_CHAN1_RISE 2
`define EV_CHAN1_FALL 3
`define EV_CHAN2_RISE 4
`define EV_CHAN2_FALL 5
`define EV_TIMER_A_ONE 6
`define EV_TIMER_A_PER 7
`define EV_TIMER_B_CMP 8
`define EV_TIMER_B_PER 9
`define EV_TRAP 10
`define EV_HALL_OK 12
`define EV_HALL_WRONG 13
`define EV_SHADOW 15
`endif

// [rtl/irq_route_pkg.sv]
// Types for the capture/compare interrupt routing stage.
// Assumes no other package.
package irq_route_pkg;
  // Set-condition pulses of the unit, one cycle each
  typedef struct packed {
    logic chan0_rise_flag;
    logic chan0_fall_flag;
    logic chan1_rise_flag;
    logic chan1_fall_flag;
    logic chan2_rise_flag;
    logic chan2_fall_flag;
    logic hall_ok_flag;
    logic shadow_xfer_flag;
    logic trap_flag;
    logic hall_wrong_flag;
    logic timer_a_one_match_flag;
    logic timer_a_period_flag;
    logic timer_b_compare_flag;
    logic timer_b_period_flag;
  } event_set_t;
  // Four service request lines
  typedef struct packed {
    logic service_line_3;
    logic service_line_2;
    logic service_line_1;
    logic service_line_0;
  } service_lines_t;
endpackage

// [verification/irq_route_sva.sv]
// Checker on the routing stage's ports, bound into it.
// Assumes full strobes on every register write.
`timescale 1ns/1ps
module irq_route_sva
  import irq_route_pkg::*;
(
  // Clock, reset and register bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events in, lines out
  input wire event_set_t events,
  input wire service_lines_t lines
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] ptr_reg, en_reg; // Shadows of the two registers
  logic [3:0] x; // Lines due after this edge
  // Enables lined up with the event vector
  wire [15:0] e = en_reg;
  wire [13:0] h = events & {e[0], e[1], e[2], e[3], e[4], e[5], e[12],
    e[15], e[10], e[13], e[6], e[7], e[8], e[9]};
  // Each group drives the line its field names
  always_comb begin
    x = 4'h0;
    for (int g = 0; g < 7; g++) if (|h[13-2*g -: 2]) x[ptr_reg[2*g +: 2]] = 1;
  end
  // Follow writes at the edge the slave takes them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {ptr_reg, en_reg} <= 32'h0;
    else if (psel && penable && pwrite && !pready) begin
      if (paddr == 12'h048) ptr_reg <= pwdata[15:0] & 16'h3fff;
      if (paddr == 12'h044) en_reg <= pwdata[15:0];
    end
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; pslverr |-> !(paddr inside {12'h044, 12'h048}); endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_rz; pready && !pwrite && paddr == 12'h048 |->
    prdata == {16'h0, ptr_reg}; endproperty
  a_rz: assert property (p_rz) else $error("pointer read");
  property p_route; 1 |=> lines == $past(x); endproperty
  a_route: assert property (p_route) else $error("lines");
  property p_quiet; h == 14'h0 |=> lines == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("stray line");
  property p_ch0; |h[13:12] |=> lines[$past(ptr_reg[1:0])]; endproperty
  a_ch0: assert property (p_ch0) else $error("chan0 line");
  property p_hall; |h[7:6] |=> lines[$past(ptr_reg[7:6])]; endproperty
  a_hall: assert property (p_hall) else $error("hall line");
  c_l3: cover property (lines.service_line_3);
  c_err: cover property (pslverr);
  c_both: cover property ($countones(h) > 1);
endmodule
bind capture_compare_irq_routing irq_route_sva chk (.*);

// [verification/irq_sink.sv]
// Interrupt controller stand-in: tallies service requests.
// Assumes one-cycle request pulses on pclk.
`timescale 1ns/1ps
module irq_sink
  import irq_route_pkg::*;
(
  // Clock, reset, lines in, tally out
  input wire logic pclk,
  input wire logic presetn,
  input wire service_lines_t lines,
  output logic [7:0] hits
);
  // Any line high in a cycle is one request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) hits <= 8'h00;
    else if (|lines) hits <= hits + 8'h01;
endmodule

// [verification/testbench.sv]
// Bench: APB register calls and event pulses with expected lines.
// Assumes full strobes; every wait is bounded.
`timescale 1ns/1ps
module testbench
  import irq_route_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf; // Partial strobes not exercised
  logic pready, pslverr, err;
  logic [15:0] p; // Pointer pattern
  logic [7:0] hits;
  event_set_t events = '0;
  service_lines_t lines;
  int miscompares = 0, check_count = 0, reqs = 0, k;
  always #2 pclk = ~pclk;
  capture_compare_irq_routing DUT (.*);
  irq_sink SINK (.*);
  task automatic chk(logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("%0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hold the request until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [15:0] d);
    int t;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0, d};
    @(posedge pclk) penable <= 1'b1;
    for (t = 0; t < 9 && pready !== 1'b1; t++) @(posedge pclk);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end
    @(posedge pclk);
  endtask
  // One-cycle events; lines compared mid-cycle after the event drops, while the line pulse stands,
  // then a rising edge is let pass so the next drive lands on an edge
  task automatic pulse(logic [13:0] e, logic [3:0] x);
    events <= e;
    @(posedge pclk) events <= '0;
    @(negedge pclk) chk(lines, x);
    reqs += (x != 0);
    @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h048, 0);
    chk(rd, 0);
    chk(err, 0);
    apb(0, 12'h044, 0);
    chk(rd, 0);
    apb(0, 12'h0f0, 0);
    chk(err, 1);
    apb(1, 12'h048, 16'hffff);
    apb(0, 12'h048, 0);
    chk(rd, 32'h3fff);
    pulse(14'h3fff, 0);
    $display("register tests done");
    apb(1, 12'h044, 16'hffff);
    for (int s = 0; s < 4; s++) begin
      p = 16'h0;
      for (int g = 0; g < 7; g++) p[2*g +: 2] = 2'(g + s);
      apb(1, 12'h048, p);
      for (int i = 0; i < 14; i++) begin
        k = 1 << p[(13 - i) / 2 * 2 +: 2];
        pulse(14'(1 << i), 4'(k));
      end
    end
    apb(1, 12'h048, 0);
    pulse(14'h3fff, 1);
    apb(1, 12'h044, 16'h0001);
    pulse(14'h1000, 0);
    pulse(14'h3000, 1);
    $display("routing tests done");
    // Let the sink's tally of the last pulse settle before reading it
    @(negedge pclk);
    chk(hits, reqs);
    results();
  end
endmodule
